// ==== verilog/pol_positioning.sv ====
`timescale 1ns/1ps

module pol_positioning
	import pol_pkg::*;
#(
	parameter int GEN_INPUTS = POL_GEN_COUNT
) (
	input  wire logic                  clock_in,
	input  wire logic                  srst_in,
	input  wire pol_od_req_t           od_req_in,
	output logic                       od_ack_out,
	output logic                       od_err_out,
	output logic [31:0]                od_rdata_out,
	input  wire logic [15:0]           control_word_in,
	input  wire pol_motion_t           motion_in,
	input  wire logic                  negative_end_switch_in,
	input  wire logic                  positive_end_switch_in,
	input  wire logic                  homing_switch_in,
	input  wire logic [GEN_INPUTS-1:0] gen_inputs_in,
	output logic                       nsp_release_out,
	output logic                       setpoint_ack_out,
	output pol_move_t                  move_out
);

	// ****************************************
	// Helpers
	// ****************************************
	// Single fold into the range; a larger excursion is shifted by one span only and can stay outside
	function automatic logic signed [31:0] fold(input logic signed [31:0] pos,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		logic signed [31:0] span;
		span = hi - lo;
		if (pos >= hi) begin
			fold = pos - span;
		end else if (pos < lo) begin
			fold = pos + span;
		end else begin
			fold = pos;
		end
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	logic [15:0]        option_ff;
	logic [15:0]        nxt_option;
	logic [31:0]        follow_ff;
	logic [31:0]        nxt_follow;
	logic [31:0]        inputs_ff;
	logic [31:0]        nxt_inputs;
	pol_state_t         state_ff;
	pol_state_t         nxt_state;
	logic signed [31:0] prev_target_ff;
	logic signed [31:0] nxt_prev_target;
	pol_move_t          move_ff;
	pol_move_t          nxt_move;

	pol_rel_t           rel_code;
	pol_hsk_t           hsk_code;
	pol_rot_t           rot_code;
	logic               nsp;
	logic               hit_option;
	logic               hit_follow;
	logic               hit_inputs;

	assign nsp = control_word_in[POL_CW_NEW_SP];

	// ****************************************
	// Field decode
	// ****************************************
	always_comb begin
		rel_code = pol_rel_t'(option_ff[POL_REL_MSB:POL_REL_LSB]);
		hsk_code = pol_hsk_t'(option_ff[POL_HSK_MSB:POL_HSK_LSB]);
		rot_code = pol_rot_t'(option_ff[POL_ROT_MSB:POL_ROT_LSB]);
		if (rel_code == POL_REL_RESERVED) begin
			rel_code = POL_REL_PREV_TARGET;
		end
		if (hsk_code == POL_HSK_RESERVED) begin
			hsk_code = POL_HSK_MASTER;
		end
	end

	// ****************************************
	// Object access
	// ****************************************
	assign hit_option = (od_req_in.index == POL_IDX_OPTION);
	assign hit_follow = (od_req_in.index == POL_IDX_FOLLOW);
	assign hit_inputs = (od_req_in.index == POL_IDX_INPUTS);

	always_comb begin
		od_ack_out   = od_req_in.valid;
		od_err_out   = 1'b0;
		od_rdata_out = 32'h00000000;
		if (od_req_in.valid) begin
			if (hit_option) begin
				od_rdata_out = {16'h0000, option_ff};
			end else if (hit_follow) begin
				od_rdata_out = follow_ff;
				od_err_out   = od_req_in.write;
			end else if (hit_inputs) begin
				od_rdata_out = inputs_ff;
				od_err_out   = od_req_in.write;
			end else begin
				od_err_out   = 1'b1;
			end
		end
	end

	always_comb begin
		nxt_option = option_ff;
		if (od_req_in.valid && od_req_in.write && hit_option) begin
			nxt_option = od_req_in.wdata[15:0] & POL_OPTION_MASK;
		end
		nxt_follow = motion_in.ramp - motion_in.actual;
		nxt_inputs = POL_INPUTS_RESET;
		nxt_inputs[POL_IN_NEG_END] = negative_end_switch_in;
		nxt_inputs[POL_IN_POS_END] = positive_end_switch_in;
		nxt_inputs[POL_IN_HOMING]  = homing_switch_in;
		nxt_inputs[POL_IN_GEN_LSB +: GEN_INPUTS] = gen_inputs_in;
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			option_ff <= POL_OPTION_RESET;
			follow_ff <= POL_FOLLOW_RESET;
			inputs_ff <= POL_INPUTS_RESET;
		end else begin
			option_ff <= nxt_option;
			follow_ff <= nxt_follow;
			inputs_ff <= nxt_inputs;
		end
	end

	// ****************************************
	// Setpoint handshake
	// ****************************************
	// A new setpoint is taken only from idle, so a held bit never retriggers
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			POL_ST_IDLE: begin
				if (nsp) begin
					nxt_state = POL_ST_ACKED;
				end
			end
			POL_ST_ACKED: begin
				unique case (hsk_code)
					POL_HSK_ON_REACHED: begin
						if (motion_in.reached) begin
							nxt_state = POL_ST_RELEASE;
						end
					end
					POL_HSK_ASAP: begin
						nxt_state = POL_ST_RELEASE;
					end
					default: begin
						if (!nsp) begin
							nxt_state = POL_ST_IDLE;
						end
					end
				endcase
			end
			POL_ST_RELEASE: begin
				if (!nsp) begin
					nxt_state = POL_ST_IDLE;
				end
			end
			default: begin
				nxt_state = POL_ST_IDLE;
			end
		endcase
	end

	// Acknowledge drops only after the release has been seen on bit 5
	assign nsp_release_out  = (state_ff == POL_ST_RELEASE);
	assign setpoint_ack_out = (state_ff == POL_ST_ACKED) || (state_ff == POL_ST_RELEASE);

	// ****************************************
	// Target and path
	// ****************************************
	always_comb begin
		logic signed [31:0] base;
		logic signed [31:0] abs_t;
		logic signed [31:0] tgt;
		logic signed [31:0] diff;
		logic signed [31:0] span;
		base = 32'h00000000;
		abs_t = 32'h00000000;
		tgt = 32'h00000000;
		diff = 32'h00000000;
		span = motion_in.range_max - motion_in.range_min;
		nxt_prev_target = prev_target_ff;
		nxt_move = move_ff;
		nxt_move.valid = 1'b0;
		if ((state_ff == POL_ST_IDLE) && nsp) begin
			unique case (rel_code)
				POL_REL_RAMP: base = motion_in.ramp;
				POL_REL_ACTUAL: base = motion_in.actual;
				default: base = prev_target_ff;
			endcase
			if (control_word_in[POL_CW_RELATIVE]) begin
				abs_t = base + motion_in.target;
			end else begin
				abs_t = motion_in.target;
			end
			nxt_prev_target = abs_t;
			if (rot_code == POL_ROT_LINEAR) begin
				tgt = fold(abs_t, motion_in.range_min, motion_in.range_max);
				diff = abs_t - motion_in.actual;
			end else begin
				tgt = fold(abs_t, motion_in.range_min, motion_in.range_max);
				diff = tgt - motion_in.actual;
				unique case (rot_code)
					POL_ROT_NEGATIVE: begin
						if (diff > 0) begin
							diff = diff - span;
						end
					end
					POL_ROT_POSITIVE: begin
						if (diff < 0) begin
							diff = diff + span;
						end
					end
					default: begin
						if (diff < 0) begin
							diff = diff + span;
						end
						if ((diff <<< 1) >= span) begin
							diff = diff - span;
						end
					end
				endcase
			end
			nxt_move.abs_target = abs_t;
			nxt_move.demand = tgt;
			nxt_move.distance = diff;
			nxt_move.valid = 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			state_ff <= POL_ST_IDLE;
			prev_target_ff <= 32'sh00000000;
			move_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			prev_target_ff <= nxt_prev_target;
			move_ff <= nxt_move;
		end
	end

	assign move_out = move_ff;

endmodule

// ==== pkg/pol_pkg.sv ====
package pol_pkg;

	// ****************************************
	// Object indices
	// ****************************************
	localparam logic [15:0] POL_IDX_OPTION    = 16'h60F2;
	localparam logic [15:0] POL_IDX_FOLLOW    = 16'h60F4;
	localparam logic [15:0] POL_IDX_INPUTS    = 16'h60FD;

	// ****************************************
	// Option word layout and reset
	// ****************************************
	localparam int          POL_REL_LSB       = 0;
	localparam int          POL_REL_MSB       = 1;
	localparam int          POL_HSK_LSB       = 4;
	localparam int          POL_HSK_MSB       = 5;
	localparam int          POL_ROT_LSB       = 6;
	localparam int          POL_ROT_MSB       = 7;
	localparam logic [15:0] POL_OPTION_MASK   = 16'h00F3;
	localparam logic [15:0] POL_OPTION_RESET  = 16'h0001;
	localparam logic [31:0] POL_FOLLOW_RESET  = 32'h00000000;
	localparam logic [31:0] POL_INPUTS_RESET  = 32'h00000000;

	// ****************************************
	// Control and status word bits
	// ****************************************
	localparam int          POL_CW_NEW_SP     = 5;
	localparam int          POL_CW_RELATIVE   = 6;
	localparam int          POL_SW_SP_ACK     = 12;

	// ****************************************
	// Input word layout
	// ****************************************
	localparam int          POL_IN_NEG_END    = 0;
	localparam int          POL_IN_POS_END    = 1;
	localparam int          POL_IN_HOMING     = 2;
	localparam int          POL_IN_GEN_LSB    = 16;
	localparam int          POL_GEN_COUNT     = 8;

	// ****************************************
	// Field codes
	// ****************************************
	typedef enum logic [1:0] {
		POL_REL_PREV_TARGET = 2'h0,
		POL_REL_RAMP        = 2'h1,
		POL_REL_ACTUAL      = 2'h2,
		POL_REL_RESERVED    = 2'h3
	} pol_rel_t;

	typedef enum logic [1:0] {
		POL_HSK_MASTER      = 2'h0,
		POL_HSK_ON_REACHED  = 2'h1,
		POL_HSK_ASAP        = 2'h2,
		POL_HSK_RESERVED    = 2'h3
	} pol_hsk_t;

	typedef enum logic [1:0] {
		POL_ROT_LINEAR      = 2'h0,
		POL_ROT_NEGATIVE    = 2'h1,
		POL_ROT_POSITIVE    = 2'h2,
		POL_ROT_SHORTEST    = 2'h3
	} pol_rot_t;

	typedef enum logic [1:0] {
		POL_ST_IDLE         = 2'h0,
		POL_ST_ACKED        = 2'h1,
		POL_ST_RELEASE      = 2'h3
	} pol_state_t;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] index;
		logic [31:0] wdata;
	} pol_od_req_t;

	typedef struct packed {
		logic signed [31:0] target;
		logic signed [31:0] actual;
		logic signed [31:0] ramp;
		logic signed [31:0] range_min;
		logic signed [31:0] range_max;
		logic               reached;
	} pol_motion_t;

	typedef struct packed {
		logic signed [31:0] abs_target;
		logic signed [31:0] demand;
		logic signed [31:0] distance;
		logic               valid;
	} pol_move_t;

endpackage

// ==== verification/pol_master_model.sv ====
`timescale 1ns/1ps
module pol_master_model (
	input  wire logic clock_in,
	input  wire logic srst_in,
	input  wire logic go_in,
	input  wire logic self_clear_in,
	input  wire logic ack_in,
	input  wire logic release_in,
	output logic      new_sp_out
);
	// ****
	// Setpoint handshake
	// ****
	logic nsp_ff;
	logic nxt_nsp;
	always_comb begin
		nxt_nsp = nsp_ff;
		if (go_in) begin
			nxt_nsp = 1'b1;
		end else if (self_clear_in && ack_in) begin
			nxt_nsp = 1'b0;
		end else if (release_in) begin
			nxt_nsp = 1'b0;
		end
		if (srst_in) begin
			nxt_nsp = 1'b0;
		end
	end
	always_ff @(posedge clock_in) begin
		nsp_ff <= nxt_nsp;
	end
	assign new_sp_out = nsp_ff;
endmodule

// ==== verification/pol_positioning_props.sv ====
`timescale 1ns/1ps
module pol_positioning_props
	import pol_pkg::*;
(
	input wire logic        clock_in,
	input wire logic        srst_in,
	input wire pol_od_req_t od_req_in,
	input wire logic        od_err_out,
	input wire logic [31:0] od_rdata_out,
	input wire logic [15:0] control_word_in,
	input wire pol_motion_t motion_in,
	input wire logic        nsp_release_out,
	input wire logic        setpoint_ack_out,
	input wire pol_move_t   move_out
);
	// ****
	// Option shadow
	// ****
	// Kept here because the checker sees no internal state
	logic [15:0] opt_ff;
	logic [15:0] nxt_opt;
	logic        rd;
	assign rd = od_req_in.valid && !od_req_in.write;
	always_comb begin
		nxt_opt = opt_ff;
		if (srst_in) begin
			nxt_opt = POL_OPTION_RESET;
		end else if (od_req_in.valid && od_req_in.write && od_req_in.index == POL_IDX_OPTION) begin
			nxt_opt = od_req_in.wdata[15:0] & POL_OPTION_MASK;
		end
	end
	always_ff @(posedge clock_in) begin
		opt_ff <= nxt_opt;
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (srst_in);
	sequence s_take;
		$rose(control_word_in[POL_CW_NEW_SP]) && !setpoint_ack_out;
	endsequence
	sequence s_ack;
		setpoint_ack_out && move_out.valid;
	endsequence
	property p_opt;
		rd && od_req_in.index == POL_IDX_OPTION |-> od_rdata_out == {16'h0000, opt_ff};
	endproperty
	a_opt: assert property (p_opt) else $error("option readback");
	property p_ro;
		od_req_in.valid && od_req_in.write && od_req_in.index != POL_IDX_OPTION |-> od_err_out;
	endproperty
	a_ro: assert property (p_ro) else $error("write not refused");
	property p_fol;
		rd && od_req_in.index == POL_IDX_FOLLOW && !$past(srst_in)
			|-> od_rdata_out == $past(motion_in.ramp - motion_in.actual);
	endproperty
	a_fol: assert property (p_fol) else $error("following error");
	property p_take;
		s_take |=> s_ack;
	endproperty
	a_take: assert property (p_take) else $error("setpoint not taken");
	property p_abs;
		move_out.valid && !$past(srst_in) && !$past(control_word_in[POL_CW_RELATIVE])
			|-> move_out.abs_target == $past(motion_in.target);
	endproperty
	a_abs: assert property (p_abs) else $error("absolute target");
	property p_asap;
		$rose(setpoint_ack_out) && opt_ff[5:4] == 2'h2 |=> nsp_release_out;
	endproperty
	a_asap: assert property (p_asap) else $error("early release");
	property p_reach;
		setpoint_ack_out && !nsp_release_out && opt_ff[5:4] == 2'h1 && motion_in.reached |=> nsp_release_out;
	endproperty
	a_reach: assert property (p_reach) else $error("release on reach");
	property p_rel;
		nsp_release_out && !control_word_in[POL_CW_NEW_SP] |=> !setpoint_ack_out;
	endproperty
	a_rel: assert property (p_rel) else $error("ack after release");
	property p_mst;
		setpoint_ack_out && opt_ff[5] == opt_ff[4] |-> !nsp_release_out;
	endproperty
	a_mst: assert property (p_mst) else $error("release in master mode");
endmodule
bind pol_positioning pol_positioning_props i_props (.clock_in(clock_in), .srst_in(srst_in),
	.od_req_in(od_req_in), .od_err_out(od_err_out), .od_rdata_out(od_rdata_out),
	.control_word_in(control_word_in), .motion_in(motion_in), .nsp_release_out(nsp_release_out),
	.setpoint_ack_out(setpoint_ack_out), .move_out(move_out));

// ==== verification/pol_positioning_tb.sv ====
`timescale 1ns/1ps
module pol_positioning_tb
	import pol_pkg::*;
();
	logic        clock_in = 1'b0;
	logic        srst_in = 1'b1;
	pol_od_req_t req = '0;
	pol_motion_t mot;
	pol_move_t   mvo;
	pol_move_t   m;
	logic [31:0] rdat;
	logic        ack, err, rls, sack, nsp;
	logic        rel6 = 1'b0, go = 1'b0, selfc = 1'b0, neg = 1'b0, pos = 1'b0, home = 1'b0;
	logic [7:0]  gen = 8'h00;
	int          bad_count = 0, total_checks = 0, cyc = 0;
	wire [15:0]  cw = {9'h000, rel6, nsp, 5'h00};
	pol_positioning i_dut (.clock_in(clock_in), .srst_in(srst_in), .od_req_in(req), .od_ack_out(ack),
		.od_err_out(err), .od_rdata_out(rdat), .control_word_in(cw), .motion_in(mot),
		.negative_end_switch_in(neg), .positive_end_switch_in(pos), .homing_switch_in(home),
		.gen_inputs_in(gen), .nsp_release_out(rls), .setpoint_ack_out(sack), .move_out(mvo));
	pol_master_model i_mst (.clock_in(clock_in), .srst_in(srst_in), .go_in(go), .self_clear_in(selfc),
		.ack_in(sack), .release_in(rls), .new_sp_out(nsp));
	always #10 clock_in = ~clock_in;
	// ****
	// Tasks
	// ****
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Read data is taken on the edge that ends the request
	task op(input logic w, input logic [15:0] i, input logic [31:0] d, input logic ee);
		@(posedge clock_in);
		req <= '{1'b1, w, i, d};
		@(posedge clock_in);
		chk("ack", 32'h00000001, 32'(ack));
		chk("err", 32'(ee), 32'(err));
		if (!w) begin
			chk("rdata", d, rdat);
		end
		req.valid <= 1'b0;
	endtask
	task mv(input logic r6, input logic [31:0] t);
		@(posedge clock_in);
		rel6 <= r6;
		mot.target <= t;
		go <= 1'b1;
		@(posedge clock_in);
		go <= 1'b0;
		m = '0;
		repeat (20) begin
			@(posedge clock_in);
			if (mvo.valid === 1'b1) begin
				m = mvo;
				break;
			end
		end
		chk("valid", 32'h1, 32'(m.valid));
		repeat (20) begin
			@(posedge clock_in);
			if (sack === 1'b0) break;
		end
	endtask
	task t_regs;
		op(1'b0, POL_IDX_OPTION, 32'h00000001, 1'b0);
		op(1'b0, POL_IDX_FOLLOW, 32'h00000000, 1'b0);
		op(1'b1, POL_IDX_OPTION, 32'hFFFFFFFF, 1'b0);
		op(1'b0, POL_IDX_OPTION, 32'h000000F3, 1'b0);
		op(1'b1, POL_IDX_FOLLOW, 32'h00000005, 1'b1);
		op(1'b1, POL_IDX_INPUTS, 32'h00000005, 1'b1);
		op(1'b0, 16'h6000, 32'h00000000, 1'b1);
		$display("regs done");
	endtask
	task t_in;
		neg <= 1'b1;
		home <= 1'b1;
		gen <= 8'hA5;
		op(1'b0, POL_IDX_INPUTS, 32'h00A50005, 1'b0);
		neg <= 1'b0;
		home <= 1'b0;
		pos <= 1'b1;
		gen <= 8'h80;
		op(1'b0, POL_IDX_INPUTS, 32'h00800002, 1'b0);
		mot.ramp <= 32'h00000064;
		mot.actual <= 32'h00000028;
		op(1'b0, POL_IDX_FOLLOW, 32'h0000003C, 1'b0);
		mot.ramp <= 32'h00000000;
		mot.actual <= 32'h00000005;
		op(1'b0, POL_IDX_FOLLOW, 32'hFFFFFFFB, 1'b0);
		$display("inputs done");
	endtask
	task t_rel;
		logic [31:0] ex [4];
		ex = '{32'h000003F2, 32'h00000136, 32'h000001FE, 32'h00000208};
		mot.ramp <= 32'h0000012C;
		mot.actual <= 32'h000001F4;
		op(1'b1, POL_IDX_OPTION, 32'h00000022, 1'b0);
		mv(1'b0, 32'h000003E8);
		chk("abs", 32'h000003E8, m.abs_target);
		for (int c = 0; c < 4; c++) begin
			op(1'b1, POL_IDX_OPTION, 32'h00000020 | 32'(c), 1'b0);
			mv(1'b1, 32'h0000000A);
			chk("abs", ex[c], m.abs_target);
		end
		$display("relative done");
	endtask
	task t_hsk;
		op(1'b1, POL_IDX_OPTION, 32'h00000010, 1'b0);
		mot.reached <= 1'b0;
		go <= 1'b1;
		@(posedge clock_in);
		go <= 1'b0;
		repeat (6) @(posedge clock_in);
		chk("release", 32'h0, 32'(rls));
		mot.reached <= 1'b1;
		repeat (2) @(posedge clock_in);
		chk("release", 32'h1, 32'(rls));
		repeat (4) @(posedge clock_in);
		chk("ack", 32'h0, 32'(sack));
		op(1'b1, POL_IDX_OPTION, 32'h00000000, 1'b0);
		selfc <= 1'b1;
		mv(1'b0, 32'h00000032);
		chk("ack", 32'h0, 32'(sack));
		op(1'b1, POL_IDX_OPTION, 32'h00000030, 1'b0);
		mv(1'b0, 32'h00000032);
		chk("ack", 32'h0, 32'(sack));
		selfc <= 1'b0;
		$display("handshake done");
	endtask
	task t_rot;
		logic [31:0] tg [8];
		logic [31:0] ed [8];
		logic [31:0] dm [8];
		logic [1:0]  rc [8];
		rc = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h3, 2'h0};
		tg = '{32'h00000320, 32'h00000320, 32'h00000064, 32'h00000320,
			32'h00000514, 32'h00000514, 32'h00000190, 32'h000003E8};
		ed = '{32'h00000258, 32'hFFFFFE70, 32'h00000384, 32'hFFFFFE70,
			32'h0000044C, 32'h00000064, 32'h000000C8, 32'h00000320};
		dm = '{32'h00000320, 32'h00000320, 32'h00000064, 32'h00000320,
			32'h0000012C, 32'h0000012C, 32'h00000190, 32'h00000000};
		mot.range_max <= 32'h000003E8;
		mot.ramp <= 32'h000000C8;
		mot.actual <= 32'h000000C8;
		for (int c = 0; c < 8; c++) begin
			op(1'b1, POL_IDX_OPTION, 32'h00000020 | (32'(rc[c]) << 6), 1'b0);
			mv(1'b0, tg[c]);
			chk("distance", ed[c], m.distance);
			chk("demand", dm[c], m.demand);
		end
		$display("rotary done");
	endtask
	// Mid-run reset: option and previous target must both come back to their reset values
	task t_rst;
		srst_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		srst_in <= 1'b0;
		op(1'b0, POL_IDX_OPTION, 32'h00000001, 1'b0);
		op(1'b1, POL_IDX_OPTION, 32'h00000020, 1'b0);
		mv(1'b1, 32'h0000000A);
		chk("abs", 32'h0000000A, m.abs_target);
		$display("reset done");
	endtask
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			test_done;
		end
	end
	initial begin
		mot <= '{32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h000007D0, 1'b1};
		repeat (6) @(posedge clock_in);
		srst_in <= 1'b0;
		t_regs;
		t_in;
		t_rel;
		t_hsk;
		t_rot;
		t_rst;
		test_done;
	end
endmodule
